//--- dlcls_pkg.sv
package dlcls_pkg;


// ==========================================================
// Timing
localparam int CLK_PERIOD_NS = 10;
localparam int LOCK_TIME_NS = 640;
localparam int STOP_TIME_NS = 2560;
localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
localparam int STOP_CYC = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
localparam int CNT_W = 16;

// ==========================================================
// Register offsets and responses
localparam logic [3:0] ADDR_CTRL = 4'h0;
localparam logic [3:0] ADDR_STAT = 4'h4;
localparam logic [3:0] ADDR_ISTAT = 4'h8;
localparam logic [3:0] ADDR_IMASK = 4'hc;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

// ==========================================================
// Configuration word layout, shared by straps and control register
localparam int CFG_W = 17;
localparam int F_BOOST = 0;
localparam int F_DSLEW = 4;
localparam int F_CSLEW = 5;
localparam int F_SPREAD = 6;
localparam int F_LOWRATE = 10;
localparam int F_IDLE = 11;
localparam int F_MON = 12;
localparam int F_OSC = 13;
localparam int F_USEREG = 16;
localparam int F_AUTO = 16;
localparam logic [CFG_W-1:0] CTRL_RST = 17'h00000;

// ==========================================================
// Interrupt bits
localparam int IRQ_W = 3;
localparam int I_LOCK = 0;
localparam int I_LOST = 1;
localparam int I_STOP = 2;
localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

// ==========================================================
// Status word layout
localparam int S_STATE = 0;
localparam int S_EQEN = 4;
localparam int S_EQSTEP = 5;
localparam int S_SSCEN = 8;
localparam int S_DEV = 9;
localparam int S_DIV = 12;

// ==========================================================
// Modulation divisors
localparam int DIV_W = 12;
localparam logic [DIV_W-1:0] DIV_HI0 = 12'h878; // 2168
localparam logic [DIV_W-1:0] DIV_HI1 = 12'h514; // 1300
localparam logic [DIV_W-1:0] DIV_HI2 = 12'h364; // 868
localparam logic [DIV_W-1:0] DIV_HI3 = 12'h28a; // 650
localparam logic [DIV_W-1:0] DIV_LO0 = 12'h26c; // 620
localparam logic [DIV_W-1:0] DIV_LO1 = 12'h172; // 370
localparam logic [DIV_W-1:0] DIV_LO2 = 12'h102; // 258
localparam logic [DIV_W-1:0] DIV_LO3 = 12'h0c0; // 192

typedef enum logic [2:0] {
   ST_OFF, ST_ACQ, ST_LOCKED, ST_SLEEP, ST_PDN
} dlcls_state_type;

// Fallback oscillator half period in clock cycles per select
function automatic logic [3:0] osc_half(input logic [2:0] sel);
   case (sel)
      3'h1: osc_half = 4'h1;
      3'h2: osc_half = 4'h2;
      3'h3: osc_half = 4'h3;
      3'h4: osc_half = 4'h4;
      3'h5: osc_half = 4'h5;
      3'h6: osc_half = 4'h6;
      3'h7: osc_half = 4'h8;
      default: osc_half = 4'h1;
   endcase
endfunction

// Byte strobes widened to a bit mask
function automatic logic [31:0] strb_mask(input logic [3:0] s);
   strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
endfunction

endpackage

//--- dlcls_cfg_decode.sv
`timescale 1ns/10ps
module dlcls_cfg_decode import dlcls_pkg::*; (
   input wire logic [3:0] boost, // Receive boost setting
   input wire logic [3:0] spread, // Spread setting
   input wire logic low_rate, // Low rate range
   output logic eq_en, // Equalizer on
   output logic [2:0] eq_step, // Gain step, 0 is 1.5 dB
   output logic ssc_en, // Spreading on
   output logic [1:0] dev_step, // Deviation step, 0 is 0.5 percent
   output logic [DIV_W-1:0] mod_div // Modulation divisor
);

logic [3:0] dm1;

// ==========================================================
// Boost and spread decode
always_comb begin
   eq_en = boost[0];
   eq_step = boost[0] ? boost[3:1] : 3'h0;
   dm1 = spread - 4'h1;
   ssc_en = (spread != 4'h0);
   dev_step = ssc_en ? dm1[1:0] : 2'h0;
   mod_div = '0;
   if (ssc_en) begin
      case (dm1[3:2])
         2'h0: mod_div = low_rate ? DIV_LO0 : DIV_HI0;
         2'h1: mod_div = low_rate ? DIV_LO1 : DIV_HI1;
         2'h2: mod_div = low_rate ? DIV_LO2 : DIV_HI2;
         default: mod_div = low_rate ? DIV_LO3 : DIV_HI3;
      endcase
   end
end

endmodule

//--- dlcls_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module dlcls_top import dlcls_pkg::*; #(
   parameter int DATA_W = 27 // Color, sync and enable width
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, low active
   input wire logic [3:0] s_awaddr, // Write address
   input wire logic s_awvalid, // Write address valid
   output logic s_awready, // Write address ready
   input wire logic [31:0] s_wdata, // Write data
   input wire logic [3:0] s_wstrb, // Write strobes
   input wire logic s_wvalid, // Write data valid
   output logic s_wready, // Write data ready
   output logic [1:0] s_bresp, // Write response
   output logic s_bvalid, // Write response valid
   input wire logic s_bready, // Write response ready
   input wire logic [3:0] s_araddr, // Read address
   input wire logic s_arvalid, // Read address valid
   output logic s_arready, // Read address ready
   output logic [31:0] s_rdata, // Read data
   output logic [1:0] s_rresp, // Read response
   output logic s_rvalid, // Read valid
   input wire logic s_rready, // Read ready
   input wire logic power_enable_pin, // Power enable pin
   input wire logic stream_present, // Embedded clock bits seen
   input wire logic rec_clk_level, // Recovered clock level
   input wire logic [DATA_W-1:0] rx_data, // Recovered parallel data
   input wire logic [CFG_W-1:0] strap_cfg, // Strap pins
   output logic eq_enable, // Equalizer on
   output logic [2:0] eq_gain_step, // Gain step
   output logic serial_monitor_en, // Monitor port on
   output logic data_slew_fast, // Data slew select
   output logic clock_slew_fast, // Clock slew select
   output logic spread_enable, // Spread on clock and data
   output logic [1:0] spread_dev_step, // Deviation step
   output logic [DIV_W-1:0] spread_mod_div, // Modulation divisor
   output logic pclk_o, // Pixel clock out
   output logic pclk_oe, // Pixel clock driven
   output logic [DATA_W-1:0] data_o, // Data out
   output logic data_oe, // Data driven
   output logic lock_o, // Link status
   output logic lock_oe, // Link status driven
   output logic pass_o, // Test pass
   output logic pass_oe, // Test pass driven
   output logic irq // Interrupt, high active
);

// ==========================================================
// Elaboration checks
if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
   $error("DATA_W out of range");
end
if (LOCK_CYC >= 2**CNT_W || STOP_CYC >= 2**CNT_W) begin : g_bad_count
   $error("Lock or stop count too wide");
end

typedef struct packed {
   logic pdb_s1;
   logic pdb_s2;
   logic sp_s1;
   logic sp_s2;
   logic sp_d;
   logic rc_s1;
   logic rc_s2;
   logic [CFG_W-1:0] strap_s1;
   logic [CFG_W-1:0] strap_s2;
   logic [CFG_W-1:0] strap_r;
   logic [CFG_W-1:0] ctrl;
   dlcls_state_type st;
   logic [CNT_W-1:0] cnt;
   logic [IRQ_W-1:0] istat;
   logic [IRQ_W-1:0] imask;
   logic aw_got;
   logic [3:0] awaddr;
   logic w_got;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic [3:0] osc_cnt;
   logic osc_lvl;
   logic pclk;
   logic src_rec;
   logic [DATA_W-1:0] data;
   logic eq_en;
   logic [2:0] eq_step;
   logic mon;
   logic dslew;
   logic cslew;
   logic ssc_en;
   logic [1:0] dev;
   logic [DIV_W-1:0] div;
} dlcls_regs_type;

dlcls_regs_type r_r;
dlcls_regs_type r_nxt;
logic [CFG_W-1:0] eff;
logic d_eq_en;
logic [2:0] d_eq_step;
logic d_ssc_en;
logic [1:0] d_dev;
logic [DIV_W-1:0] d_div;
logic [IRQ_W-1:0] ev;
logic [IRQ_W-1:0] clr;
logic [31:0] wm;
logic wr_fire;
logic osc_on;
logic want_rec;
logic sw_pend;
logic new_lvl;
logic [3:0] half;

// ==========================================================
// Effective configuration: register when selected, else straps
assign eff = r_r.ctrl[F_USEREG] ? r_r.ctrl : r_r.strap_r;
assign osc_on = (eff[F_OSC+:3] != 3'h0) && (r_r.st != ST_OFF) &&
   (r_r.st != ST_LOCKED);
assign want_rec = (r_r.st == ST_LOCKED);
assign sw_pend = (want_rec != r_r.src_rec);
assign new_lvl = want_rec ? r_r.rc_s2 : r_r.osc_lvl;
assign half = osc_half(eff[F_OSC+:3]);
assign wr_fire = r_r.aw_got && r_r.w_got;
assign wm = strb_mask(r_r.wstrb);

dlcls_cfg_decode u_dec (
   .boost(eff[F_BOOST+:4]),
   .spread(eff[F_SPREAD+:4]),
   .low_rate(eff[F_LOWRATE]),
   .eq_en(d_eq_en),
   .eq_step(d_eq_step),
   .ssc_en(d_ssc_en),
   .dev_step(d_dev),
   .mod_div(d_div)
);

// ==========================================================
// Next state
always_comb begin
   r_nxt = r_r;
   ev = '0;
   clr = '0;
   // Pin synchronisers
   r_nxt.pdb_s1 = power_enable_pin;
   r_nxt.pdb_s2 = r_r.pdb_s1;
   r_nxt.sp_s1 = stream_present;
   r_nxt.sp_s2 = r_r.sp_s1;
   r_nxt.sp_d = r_r.sp_s2;
   r_nxt.rc_s1 = rec_clk_level;
   r_nxt.rc_s2 = r_r.rc_s1;
   r_nxt.strap_s1 = strap_cfg;
   r_nxt.strap_s2 = r_r.strap_s1;
   // Run length of the present stream level
   if (r_r.sp_s2 != r_r.sp_d) begin
      r_nxt.cnt = '0;
   end else if (r_r.cnt != {CNT_W{1'b1}}) begin
      r_nxt.cnt = r_r.cnt + 1'b1;
   end
   // Link state machine
   case (r_r.st)
      ST_OFF: begin
         if (r_r.pdb_s2) begin
            r_nxt.st = ST_ACQ;
            r_nxt.strap_r = r_r.strap_s2;
         end
      end
      ST_ACQ: begin
         if (r_r.sp_s2 && r_r.cnt >= CNT_W'(LOCK_CYC - 1)) begin
            r_nxt.st = ST_LOCKED;
            ev[I_LOCK] = 1'b1;
         end else if (!r_r.sp_s2 && r_r.cnt >= CNT_W'(STOP_CYC - 1)) begin
            r_nxt.st = r_r.strap_r[F_AUTO] ? ST_PDN : ST_SLEEP;
            ev[I_STOP] = 1'b1;
         end
      end
      ST_LOCKED: begin
         if (!r_r.sp_s2) begin
            r_nxt.st = ST_ACQ;
            ev[I_LOST] = 1'b1;
         end
      end
      ST_SLEEP, ST_PDN: begin
         if (r_r.sp_s2) begin
            r_nxt.st = ST_ACQ;
         end
      end
      default: r_nxt.st = ST_OFF;
   endcase
   if (!r_r.pdb_s2) begin
      r_nxt.st = ST_OFF;
   end
   // Register writes, address and data taken in either order
   if (s_awvalid && s_awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.awaddr = s_awaddr;
   end
   if (s_wvalid && s_wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_wdata;
      r_nxt.wstrb = s_wstrb;
   end
   if (wr_fire) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      case (r_r.awaddr)
         ADDR_CTRL: r_nxt.ctrl = CFG_W'((32'(r_r.ctrl) & ~wm) |
            (r_r.wdata & wm));
         ADDR_STAT: r_nxt.bresp = RESP_OKAY;
         ADDR_ISTAT: clr = IRQ_W'(r_r.wdata & wm);
         ADDR_IMASK: r_nxt.imask = IRQ_W'((32'(r_r.imask) & ~wm) |
            (r_r.wdata & wm));
         default: r_nxt.bresp = RESP_SLVERR;
      endcase
   end
   if (r_r.bvalid && s_bready) begin
      r_nxt.bvalid = 1'b0;
   end
   // Sticky events, a new event beats a clear in the same cycle
   r_nxt.istat = (r_r.istat & ~clr) | ev;
   // Power-down resets registers, sleep keeps them
   if (r_r.st == ST_OFF || r_r.st == ST_PDN) begin
      r_nxt.ctrl = CTRL_RST;
      r_nxt.istat = IRQ_RST;
      r_nxt.imask = IRQ_RST;
   end
   // Register reads
   if (s_arvalid && s_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = RESP_OKAY;
      r_nxt.rdata = '0;
      case (s_araddr)
         ADDR_CTRL: r_nxt.rdata = 32'(r_r.ctrl);
         ADDR_STAT: begin
            r_nxt.rdata[S_STATE+:3] = r_r.st;
            r_nxt.rdata[S_EQEN] = r_r.eq_en;
            r_nxt.rdata[S_EQSTEP+:3] = r_r.eq_step;
            r_nxt.rdata[S_SSCEN] = r_r.ssc_en;
            r_nxt.rdata[S_DEV+:2] = r_r.dev;
            r_nxt.rdata[S_DIV+:DIV_W] = r_r.div;
         end
         ADDR_ISTAT: r_nxt.rdata = 32'(r_r.istat);
         ADDR_IMASK: r_nxt.rdata = 32'(r_r.imask);
         default: r_nxt.rresp = RESP_SLVERR;
      endcase
   end else if (r_r.rvalid && s_rready) begin
      r_nxt.rvalid = 1'b0;
   end
   // Fallback oscillator
   if (osc_on) begin
      if (r_r.osc_cnt + 4'h1 >= half) begin
         r_nxt.osc_cnt = 4'h0;
         r_nxt.osc_lvl = !r_r.osc_lvl;
      end else begin
         r_nxt.osc_cnt = r_r.osc_cnt + 4'h1;
      end
   end else begin
      r_nxt.osc_cnt = 4'h0;
   end
   // Clock source switch holds the level until the sources agree; a switch to no source goes at once
   if (sw_pend) begin
      if (new_lvl == r_r.pclk || (!want_rec && !osc_on)) begin
         r_nxt.src_rec = want_rec;
      end
   end else if (want_rec) begin
      r_nxt.pclk = r_r.rc_s2;
   end else if (osc_on) begin
      r_nxt.pclk = r_r.osc_lvl;
   end else begin
      r_nxt.pclk = 1'b0;
   end
   // Data passes only while locked
   r_nxt.data = (r_nxt.st == ST_LOCKED) ? rx_data : '0;
   // Registered settings
   r_nxt.eq_en = d_eq_en;
   r_nxt.eq_step = d_eq_step;
   r_nxt.mon = r_r.ctrl[F_MON];
   r_nxt.dslew = eff[F_DSLEW];
   r_nxt.cslew = eff[F_CSLEW];
   r_nxt.ssc_en = d_ssc_en;
   r_nxt.dev = d_dev;
   r_nxt.div = d_div;
end

// ==========================================================
// State register
always_ff @(posedge aclk) begin
   if (!aresetn) begin
      r_r <= '0;
      r_r.st <= ST_OFF;
      r_r.ctrl <= CTRL_RST;
   end else begin
      r_r <= r_nxt;
   end
end

// ==========================================================
// Pin drive by state and idle select
always_comb begin
   lock_oe = (r_r.st != ST_OFF);
   pass_oe = lock_oe;
   if (r_r.st == ST_OFF) begin
      pclk_oe = 1'b0;
      data_oe = 1'b0;
   end else if (r_r.st == ST_LOCKED || osc_on) begin
      pclk_oe = 1'b1;
      data_oe = 1'b1;
   end else begin
      pclk_oe = !eff[F_IDLE];
      data_oe = !eff[F_IDLE];
   end
end

// Bus handshakes and outputs
assign s_awready = !r_r.aw_got && !r_r.bvalid;
assign s_wready = !r_r.w_got && !r_r.bvalid;
assign s_bvalid = r_r.bvalid;
assign s_bresp = r_r.bresp;
assign s_arready = !r_r.rvalid;
assign s_rvalid = r_r.rvalid;
assign s_rdata = r_r.rdata;
assign s_rresp = r_r.rresp;
assign lock_o = (r_r.st == ST_LOCKED);
assign pass_o = lock_o;
assign pclk_o = r_r.pclk;
assign data_o = r_r.data;
assign irq = |(r_r.istat & r_r.imask);
assign eq_enable = r_r.eq_en;
assign eq_gain_step = r_r.eq_step;
assign serial_monitor_en = r_r.mon;
assign data_slew_fast = r_r.dslew;
assign clock_slew_fast = r_r.cslew;
assign spread_enable = r_r.ssc_en;
assign spread_dev_step = r_r.dev;
assign spread_mod_div = r_r.div;

// ==========================================================
// Assertions
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);

a_eq_off_low: assert property (!eff[F_BOOST] |=> !eq_enable)
   else $error("Equalizer on with low boost bit");
a_eq_step_map: assert property (eff[F_BOOST] ##1 1'b1 |->
   eq_gain_step == $past(eff[F_BOOST+1+:3]))
   else $error("Gain step mismatch");
a_mon_reg_only: assert property (!r_r.ctrl[F_MON] |=>
   !serial_monitor_en)
   else $error("Monitor on without register bit");
a_spread_off: assert property (eff[F_SPREAD+:4] == 4'h0 |=>
   !spread_enable && spread_dev_step == 2'h0)
   else $error("Spread not off");
a_div_high: assert property (!eff[F_LOWRATE] &&
   eff[F_SPREAD+:4] inside {[4'h1:4'h4]} |=>
   spread_mod_div == 12'h878)
   else $error("Wrong high range divisor");
a_div_low: assert property (eff[F_LOWRATE] &&
   eff[F_SPREAD+:4] >= 4'hd |=> spread_mod_div == 12'h0c0)
   else $error("Wrong low range divisor");
a_lock_rise: assert property (r_r.st == ST_ACQ && r_r.pdb_s2 &&
   r_r.sp_s2 && r_r.cnt >= CNT_W'(LOCK_CYC - 1) |=>
   lock_o && pass_o)
   else $error("Lock not raised");
a_loss_drop: assert property (lock_o && !r_r.sp_s2 |=>
   !lock_o && lock_oe[*2])
   else $error("Lock not dropped on loss");
a_off_float: assert property ($fell(r_r.pdb_s2) |=> !pclk_oe &&
   !data_oe && !lock_oe && !pass_oe)
   else $error("Outputs driven with power off");
a_pdn_clear: assert property (r_r.st == ST_PDN |=>
   r_r.ctrl == CTRL_RST && r_r.imask == IRQ_RST)
   else $error("Registers kept in power-down");
a_sleep_keep: assert property (r_r.st == ST_SLEEP && !wr_fire |=>
   $stable(r_r.ctrl))
   else $error("Registers lost in sleep");
a_pclk_hold: assert property (sw_pend |=> $stable(pclk_o))
   else $error("Clock moved during source switch");
a_idle_high: assert property (r_r.st == ST_SLEEP && eff[F_IDLE] &&
   !osc_on |-> !pclk_oe && !data_oe && lock_oe && !lock_o)
   else $error("Idle high drive wrong");
a_lost_sticky: assert property (ev[I_LOST] |=> r_r.istat[I_LOST] ||
   $past(r_r.st == ST_OFF || r_r.st == ST_PDN))
   else $error("Loss event dropped");

c_lock: cover property ($rose(lock_o));
c_loss: cover property (lock_o ##1 !lock_o);
c_sleep: cover property (r_r.st == ST_SLEEP ##[1:100] lock_o);
c_pdn: cover property (r_r.st == ST_PDN);

endmodule

//--- dlcls_ser_model.sv
`timescale 1ns/10ps
module dlcls_ser_model (
   input wire logic aclk, // Clock
   input wire logic run, // Stream running
   input wire logic [26:0] payload, // Word to send
   output logic stream_present, // Embedded clock bits seen
   output logic rec_clk_level, // Recovered clock level
   output logic [26:0] rx_data // Recovered word
);
   // Clock stands still when stopped; idle data churns every cycle
   initial begin
      stream_present = 1'b0;
      rec_clk_level = 1'b0;
      rx_data = 27'h0;
   end
   always @(posedge aclk) begin
      stream_present <= run;
      if (run) begin
         rec_clk_level <= ~rec_clk_level;
         rx_data <= payload;
      end else begin
         rx_data <= ~rx_data;
      end
   end
endmodule

//--- deser_link_config_and_lock_status_tb_top.sv
`timescale 1ns/10ps
module deser_link_config_and_lock_status_tb_top import dlcls_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
   logic [31:0] s_wdata = 32'h0, s_rdata, rnd = 32'hcec3;
   logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
   logic s_arvalid = 1'b0, s_rready = 1'b0, power_enable_pin = 1'b0;
   logic run = 1'b0;
   logic [CFG_W-1:0] strap_cfg = 17'h00000, v;
   logic [26:0] payload = 27'h0, rx_data, data_o;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
   logic stream_present, rec_clk_level, eq_enable, serial_monitor_en;
   logic data_slew_fast, clock_slew_fast, spread_enable, pclk_o, pclk_oe;
   logic data_oe, lock_o, lock_oe, pass_o, pass_oe;
   logic [1:0] s_bresp, s_rresp, spread_dev_step;
   logic [2:0] eq_gain_step;
   logic [3:0] b, s;
   logic [DIV_W-1:0] spread_mod_div;
   logic [DIV_W-1:0] dv [8] = '{DIV_HI0, DIV_HI1, DIV_HI2, DIV_HI3,
      DIV_LO0, DIV_LO1, DIV_LO2, DIV_LO3};
   logic [31:0] rd_q [$];
   int fails = 0, compares = 0;

   dlcls_top dlcls_top_inst (.*);
   dlcls_ser_model dlcls_ser_model_inst (.*);

   // Clock
   always #5 aclk = ~aclk;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Bus write, both channels offered together
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, tr;
      tr = 1'b0;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = s_awvalid & s_awready;
         tw = s_wvalid & s_wready;
         tr = s_bvalid === 1'b1;
         if (tr) begin
            chk("bresp", RESP_OKAY, s_bresp);
         end
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tr) s_bready <= 1'b0;
      end
   endtask
   // Bus read; expected data noted for the monitor
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic ta, tr;
      tr = 1'b0;
      rd_q.push_back(e);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      while (!tr) begin
         @(negedge aclk);
         ta = s_arvalid & s_arready;
         tr = s_rvalid === 1'b1;
         @(posedge aclk);
         if (ta) s_arvalid <= 1'b0;
         if (tr) s_rready <= 1'b0;
      end
   endtask
   task automatic wait_lock();
      int n;
      n = 0;
      @(negedge aclk);
      while (lock_o !== 1'b1 && n < 400) begin
         @(negedge aclk);
         n++;
      end
      chk("lock_o", 1'b1, lock_o);
   endtask
   task automatic pins_float();
      @(negedge aclk);
      chk("lock_oe", 1'b0, lock_oe);
      chk("pass_oe", 1'b0, pass_oe);
      chk("pclk_oe", 1'b0, pclk_oe);
      chk("data_oe", 1'b0, data_oe);
   endtask
   task automatic final_report();
      // A read still waiting for its answer counts as a mismatch
      if (rd_q.size() != 0) begin
         fails++;
      end
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Read monitor takes the oldest note
   always @(negedge aclk) begin
      if (s_rvalid && s_rready && rd_q.size() > 0) begin
         chk("rdata", rd_q.pop_front(), s_rdata);
         chk("rresp", RESP_OKAY, s_rresp);
      end
   end

   // Watchdog
   initial begin
      #100000;
      fails++;
      final_report();
   end

   // ==========================================================
   // Tests
   initial begin
      tick(12);
      aresetn <= 1'b1;
      tick(3);
      pins_float();
      rd(ADDR_CTRL, 32'h0);
      strap_cfg <= 17'h00143;
      tick(1);
      power_enable_pin <= 1'b1;
      tick(6);
      @(negedge aclk);
      chk("lock_oe", 1'b1, lock_oe);
      chk("lock_o", 1'b0, lock_o);
      chk("data_o", 27'h0, data_o);
      chk("eq_step", 3'h1, eq_gain_step);
      chk("mod_div", DIV_HI1, spread_mod_div);
      $display("done: power up");
      for (int i = 0; i < 32; i++) begin
         s = i[3:0];
         b = s ^ 4'h5;
         v = {1'b1, 3'h0, i[4], 1'b0, i[4], s, i[1], i[0], b};
         wr(ADDR_CTRL, {15'h0, v});
         tick(3);
         @(negedge aclk);
         chk("eq_en", b[0], eq_enable);
         chk("eq_step", b[0] ? b[3:1] : 3'h0, eq_gain_step);
         chk("mon", i[4], serial_monitor_en);
         chk("dslew", i[0], data_slew_fast);
         chk("cslew", i[1], clock_slew_fast);
         chk("ssc_en", s != 4'h0, spread_enable);
         if (s != 4'h0) begin
            chk("dev", 2'(s[1:0] - 2'h1), spread_dev_step);
         end
         b = s - 4'h1;
         chk("div", s != 4'h0 ? dv[{i[4], b[3:2]}] : 12'h0,
            spread_mod_div);
      end
      rd(ADDR_CTRL, {15'h0, v});
      $display("done: decode");
      wr(ADDR_ISTAT, 32'h7);
      wr(ADDR_IMASK, 32'h1);
      wr(ADDR_CTRL, 32'h10000);
      run <= 1'b1;
      wait_lock();
      chk("pass_o", 1'b1, pass_o);
      chk("pclk_oe", 1'b1, pclk_oe);
      chk("irq", 1'b1, irq);
      repeat (4) begin
         @(posedge aclk);
         rnd = lfsr(rnd);
         payload <= rnd[26:0];
         tick(3);
         @(negedge aclk);
         chk("data_o", rnd[26:0], data_o);
      end
      rd(ADDR_ISTAT, 32'h1);
      wr(ADDR_ISTAT, 32'h1);
      run <= 1'b0;
      tick(6);
      @(negedge aclk);
      chk("lock_o", 1'b0, lock_o);
      chk("data_o", 27'h0, data_o);
      chk("data_oe", 1'b1, data_oe);
      chk("pass_o", 1'b0, pass_o);
      chk("irq", 1'b0, irq);
      wr(ADDR_CTRL, 32'h10800);
      tick(3);
      @(negedge aclk);
      chk("pclk_oe", 1'b0, pclk_oe);
      chk("data_oe", 1'b0, data_oe);
      chk("lock_oe", 1'b1, lock_oe);
      tick(300);
      rd(ADDR_CTRL, 32'h10800);
      rd(ADDR_ISTAT, 32'h6);
      // Fallback oscillator drives the clock while asleep
      wr(ADDR_CTRL, 32'h12800);
      tick(2);
      @(negedge aclk);
      v[0] = pclk_o;
      @(negedge aclk);
      chk("pclk_oe", 1'b1, pclk_oe);
      chk("pclk_o", !v[0], pclk_o);
      @(posedge aclk);
      run <= 1'b1;
      wait_lock();
      $display("done: lock, loss, sleep");
      @(posedge aclk);
      power_enable_pin <= 1'b0;
      tick(5);
      pins_float();
      @(posedge aclk);
      strap_cfg <= 17'h10000;
      run <= 1'b0;
      tick(2);
      power_enable_pin <= 1'b1;
      tick(6);
      wr(ADDR_CTRL, 32'h10013);
      rd(ADDR_CTRL, 32'h10013);
      tick(300);
      rd(ADDR_CTRL, 32'h0);
      @(negedge aclk);
      chk("data_oe", 1'b1, data_oe);
      chk("data_o", 27'h0, data_o);
      chk("pclk_o", 1'b0, pclk_o);
      @(posedge aclk);
      run <= 1'b1;
      wait_lock();
      $display("done: auto-detect");
      final_report();
   end
endmodule
